// ===== pkg/bsc_pkg.sv
// Shared constants and types for the boot strap capture block
package bsc_pkg;

	// Strap sampling width and pin positions on the address bus
	localparam int BSC_AW = 20;
	localparam int BSC_PIN_PCI_ROLE = 19;
	localparam int BSC_PIN_SHARED = 18;
	localparam int BSC_PIN_RSVD_HI = 15;
	localparam int BSC_PIN_SYSDIV = 13;
	localparam int BSC_PIN_BYTE_ORDER = 12;
	localparam int BSC_PIN_PCIDIV = 10;
	localparam int BSC_PIN_AUDIO = 9;
	localparam int BSC_PIN_BOOT_SRC = 8;
	localparam int BSC_PIN_BOOT_DIV = 6;
	localparam int BSC_PIN_RSVD_LO = 3;
	localparam int BSC_PIN_MULT = 0;

	// Register byte offsets, one word each
	localparam int BSC_OFS_W = 8;
	localparam logic [7:0] BSC_OFS_CHIP = 8'h00;
	localparam logic [7:0] BSC_OFS_PIN = 8'h04;
	localparam logic [7:0] BSC_OFS_BOOT = 8'h08;
	localparam logic [7:0] BSC_OFS_IMAGE = 8'h0c;
	localparam logic [7:0] BSC_OFS_CTRL = 8'h10;
	localparam logic [7:0] BSC_OFS_STATUS = 8'h14;
	localparam int BSC_CTRL_CHECK_BIT = 0;
	localparam logic [2:0] BSC_HSIZE_WORD = 3'h2;

	// Reset values: pull-ups make an unstrapped pin read high
	localparam logic [19:0] BSC_RAW_RST = 20'hfffff;
	localparam logic [6:0] BSC_CG_RST = 7'h7f;
	localparam logic BSC_CHECK_EN_RST = 1'h1;

	// Fields latched at main reset release
	typedef struct packed {
		logic pci_role_field;
		logic shared_pin_select_upper;
		logic byte_order_field;
		logic audio_link_pin_select;
		logic boot_source_field;
		logic [1:0] boot_bus_clock_divide;
	} bsc_main_cfg_t;

	// Fields latched at clock-generator reset release
	typedef struct packed {
		logic [1:0] system_clock_divisor_field;
		logic [1:0] pci_clock_divisor_field;
		logic [2:0] core_multiplier_field;
	} bsc_cg_cfg_t;

	// Register request from the bus slave
	typedef struct packed {
		logic wr;
		logic [7:0] wr_addr;
		logic [31:0] wr_data;
		logic [7:0] rd_addr;
	} bsc_reg_req_t;

	// Register layouts, least significant field last
	typedef struct packed {
		logic [22:0] zero;
		logic [2:0] core_mult;
		logic [1:0] pci_div;
		logic [1:0] sys_div;
		logic byte_order;
		logic pci_role;
	} bsc_chip_reg_t;

	typedef struct packed {
		logic [27:0] zero;
		logic reserved_low;
		logic pci_boot_conflict;
		logic cg_done;
		logic main_done;
	} bsc_status_reg_t;

endpackage

// ===== src/bsc_ahb_slave.sv
// AHB-Lite slave front end, zero wait states, registered read data
`timescale 1ns/10ps
module bsc_ahb_slave
	import bsc_pkg::*;
#(
	parameter int AW = BSC_OFS_W
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [AW-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output bsc_reg_req_t req,
	input wire logic [31:0] rd_data
);

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
	} bsc_ahb_state_t;

	bsc_ahb_state_t state_reg;
	bsc_ahb_state_t state_next;
	logic addr_phase;

	initial
	begin
		if (AW != BSC_OFS_W)
			$error("bsc_ahb_slave: AW must equal the register offset width");
	end

	// NONSEQ or SEQ while the bus is ready opens an address phase
	assign addr_phase = hsel & htrans[1] & hready;

	// Reads are decoded in the address phase so data is a flop output
	always_comb
	begin
		state_next = state_reg;
		state_next.wr_pend = 1'b0;
		if (addr_phase)
		begin
			state_next.wr_pend = hwrite & (hsize == BSC_HSIZE_WORD);
			state_next.wr_addr = haddr;
			if (!hwrite)
				state_next.hrdata = rd_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign req.wr = state_reg.wr_pend;
	assign req.wr_addr = state_reg.wr_addr;
	assign req.wr_data = hwdata;
	assign req.rd_addr = haddr;
	assign hrdata = state_reg.hrdata;
	assign hreadyout = 1'b1; // Never stalls
	assign hresp = 1'b0; // Always OKAY

endmodule

// ===== src/bsc_boot_strap_capture.sv
// Boot strap capture: latches address-pin straps at reset release
//
// How it works
// - At main reset release address pin 19 sets the PCI role, low satellite and high host.
// - At main reset release pin 18 picks ECC check bits (high) or port bits 15..8 (low) on the shared pins.
// - At clock-generator reset release pins 14:13 give the system clock divisor, LL 4, LH 3, HL 2, HH 1.
// - At main reset release pin 12 sets byte order, low little endian and high big endian.
// - At clock-generator reset release pins 11:10 give the PCI clock divisor, LL 2.5, LH 3, HL 5, HH 6.
// - At main reset release pin 9 hands port bits 7..2 to the audio link when high.
// - At main reset release pin 8 selects boot from bus channel 0 (high) or from PCI memory (low).
// - At main reset release pins 7:6 give the boot bus clock divide, HH 1, HL 2, LH 2, LL ambiguous.
// - At clock-generator reset release pins 2:0 give the core multiplier, with HLL ambiguous.
// - The two low multiplier strap bits are copied into the core's own ratio field.
// - Each strap is sampled on the first edge after its reset lifts, high as 1 and low as 0.
`timescale 1ns/10ps
module bsc_boot_strap_capture
	import bsc_pkg::*;
#(
	parameter logic [5:0] CORE_HLL_X2 = 6'h06,
	parameter logic [2:0] BOOT_LL_DIV = 3'h3
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clock_generator_reset_n,
	input wire logic [BSC_AW-1:0] addr_pins,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output bsc_main_cfg_t main_cfg,
	output bsc_cg_cfg_t cg_cfg,
	output logic [1:0] core_ratio_copy_field,
	output logic [2:0] sys_div,
	output logic [3:0] pci_div_x2,
	output logic [5:0] core_mult_x2,
	output logic [2:0] boot_div,
	output logic main_captured,
	output logic cg_captured
);

	typedef struct packed {
		logic check_en;
		logic pci_boot_conflict;
		logic reserved_low;
		logic [2:0] sys_div;
		logic [3:0] pci_div_x2;
		logic [5:0] core_mult_x2;
		logic [2:0] boot_div;
	} bsc_top_state_t;

	bsc_top_state_t state_reg;
	bsc_top_state_t state_next;
	bsc_reg_req_t req;
	logic [31:0] rd_data;
	logic [19:0] raw;
	logic [6:0] cg_raw;
	bsc_chip_reg_t chip_word;
	bsc_status_reg_t status_word;

	initial
	begin
		if (CORE_HLL_X2 == 6'h00 || BOOT_LL_DIV == 3'h0)
			$error("bsc_boot_strap_capture: ambiguous ratios must be nonzero");
	end

	// Whole address image taken at main reset release
	bsc_capture #(
		.W(BSC_AW),
		.RST(BSC_RAW_RST)
	) u_main_cap (
		.hclk(hclk),
		.hresetn(hresetn),
		.hold_n(1'b1),
		.pins(addr_pins),
		.value(raw),
		.captured(main_captured)
	);

	// Clock ratio straps sit on the clock-generator reset alone, so a
	// main reset keeps the captured straps; the decoded ratio outputs still reset with hresetn
	bsc_capture #(
		.W(7),
		.RST(BSC_CG_RST)
	) u_cg_cap (
		.hclk(hclk),
		.hresetn(clock_generator_reset_n),
		.hold_n(1'b1),
		.pins({addr_pins[BSC_PIN_SYSDIV +: 2], addr_pins[BSC_PIN_PCIDIV +: 2], addr_pins[BSC_PIN_MULT +: 3]}),
		.value(cg_raw),
		.captured(cg_captured)
	);

	// Main-reset fields are fixed slices of the frozen image
	assign main_cfg.pci_role_field = raw[BSC_PIN_PCI_ROLE];
	assign main_cfg.shared_pin_select_upper = raw[BSC_PIN_SHARED];
	assign main_cfg.byte_order_field = raw[BSC_PIN_BYTE_ORDER];
	assign main_cfg.audio_link_pin_select = raw[BSC_PIN_AUDIO];
	assign main_cfg.boot_source_field = raw[BSC_PIN_BOOT_SRC];
	assign main_cfg.boot_bus_clock_divide = raw[BSC_PIN_BOOT_DIV +: 2];

	// Clock-generator fields and the core's ratio copy
	assign cg_cfg = bsc_cg_cfg_t'(cg_raw);
	assign core_ratio_copy_field = cg_cfg.core_multiplier_field[1:0];

	// Register bus front end
	bsc_ahb_slave #(
		.AW(BSC_OFS_W)
	) u_ahb (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.req(req),
		.rd_data(rd_data)
	);

	// Decode ratios one cycle behind the fields, control write and board checks
	always_comb
	begin
		state_next = state_reg;
		case (cg_cfg.system_clock_divisor_field)
			2'h0: state_next.sys_div = 3'h4;
			2'h1: state_next.sys_div = 3'h3;
			2'h2: state_next.sys_div = 3'h2;
			default: state_next.sys_div = 3'h1;
		endcase
		// Half steps exist, so the PCI divisor is kept doubled
		case (cg_cfg.pci_clock_divisor_field)
			2'h0: state_next.pci_div_x2 = 4'h5;
			2'h1: state_next.pci_div_x2 = 4'h6;
			2'h2: state_next.pci_div_x2 = 4'ha;
			default: state_next.pci_div_x2 = 4'hc;
		endcase
		// HLL is listed twice; parameter picks which ratio is built
		case (cg_cfg.core_multiplier_field)
			3'h7: state_next.core_mult_x2 = 6'h04;
			3'h6: state_next.core_mult_x2 = 6'h05;
			3'h5: state_next.core_mult_x2 = 6'h06;
			3'h4: state_next.core_mult_x2 = CORE_HLL_X2;
			3'h3: state_next.core_mult_x2 = 6'h10;
			3'h2: state_next.core_mult_x2 = 6'h14;
			3'h1: state_next.core_mult_x2 = 6'h18;
			default: state_next.core_mult_x2 = 6'h20;
		endcase
		case (main_cfg.boot_bus_clock_divide)
			2'h3: state_next.boot_div = 3'h1;
			2'h2: state_next.boot_div = 3'h2;
			2'h1: state_next.boot_div = 3'h2;
			default: state_next.boot_div = BOOT_LL_DIV;
		endcase
		if (req.wr && req.wr_addr == BSC_OFS_CTRL)
			state_next.check_en = req.wr_data[BSC_CTRL_CHECK_BIT];
		// Flags are levels from the frozen image, so they cannot miss an event
		state_next.pci_boot_conflict = state_reg.check_en & main_captured & ~main_cfg.boot_source_field
			& (main_cfg.boot_bus_clock_divide != 2'h3);
		state_next.reserved_low = state_reg.check_en & main_captured
			& ~(&{raw[BSC_PIN_RSVD_HI +: 3], raw[BSC_PIN_RSVD_LO +: 3]});
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_reg <= '{check_en: BSC_CHECK_EN_RST, sys_div: 3'h1, pci_div_x2: 4'hc,
				core_mult_x2: 6'h04, boot_div: 3'h1, default: '0};
		else
			state_reg <= state_next;
	end

	assign sys_div = state_reg.sys_div;
	assign pci_div_x2 = state_reg.pci_div_x2;
	assign core_mult_x2 = state_reg.core_mult_x2;
	assign boot_div = state_reg.boot_div;

	// Register images; unmapped offsets read zero
	always_comb
	begin
		chip_word = '0;
		chip_word.core_mult = cg_cfg.core_multiplier_field;
		chip_word.pci_div = cg_cfg.pci_clock_divisor_field;
		chip_word.sys_div = cg_cfg.system_clock_divisor_field;
		chip_word.byte_order = main_cfg.byte_order_field;
		chip_word.pci_role = main_cfg.pci_role_field;
		status_word = '0;
		status_word.reserved_low = state_reg.reserved_low;
		status_word.pci_boot_conflict = state_reg.pci_boot_conflict;
		status_word.cg_done = cg_captured;
		status_word.main_done = main_captured;
		case (req.rd_addr)
			BSC_OFS_CHIP: rd_data = chip_word;
			BSC_OFS_PIN: rd_data = {30'h0, main_cfg.audio_link_pin_select, main_cfg.shared_pin_select_upper};
			BSC_OFS_BOOT: rd_data = {29'h0, main_cfg.boot_bus_clock_divide, main_cfg.boot_source_field};
			BSC_OFS_IMAGE: rd_data = {12'h0, raw};
			BSC_OFS_CTRL: rd_data = {31'h0, state_reg.check_en};
			BSC_OFS_STATUS: rd_data = status_word;
			default: rd_data = 32'h0;
		endcase
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Checks run on the bus clock and sleep through a main reset, so a
	// check that spans a release only compares values taken after it
	// Main straps match the pins seen on the capture edge
	a_role_latch: assert property ($rose(main_captured) |->
		main_cfg.pci_role_field == $past(addr_pins[BSC_PIN_PCI_ROLE]))
		else $error("PCI role not latched from pin 19");
	a_shared_latch: assert property ($rose(main_captured) |->
		main_cfg.shared_pin_select_upper == $past(addr_pins[BSC_PIN_SHARED]))
		else $error("shared pin select not latched");
	a_order_latch: assert property ($rose(main_captured) |->
		main_cfg.byte_order_field == $past(addr_pins[BSC_PIN_BYTE_ORDER]))
		else $error("byte order not latched");
	a_audio_latch: assert property ($rose(main_captured) |->
		main_cfg.audio_link_pin_select == $past(addr_pins[BSC_PIN_AUDIO]))
		else $error("audio link select not latched");
	a_boot_source: assert property ($rose(main_captured) |->
		main_cfg.boot_source_field == $past(addr_pins[BSC_PIN_BOOT_SRC]))
		else $error("boot source not latched");
	a_image_latch: assert property ($rose(main_captured) |->
		raw == $past(addr_pins))
		else $error("strap image differs from the pins");
	a_boot_divide: assert property ($rose(main_captured) && $past(addr_pins[7:6]) == 2'h3 |=>
		boot_div == 3'h1)
		else $error("boot divide HH not 1");
	a_boot_half: assert property ($rose(main_captured) && ^$past(addr_pins[7:6]) |=>
		boot_div == 3'h2)
		else $error("boot divide HL or LH not 2");
	a_boot_slow: assert property ($rose(main_captured) && $past(addr_pins[7:6]) == 2'h0 |=>
		boot_div == BOOT_LL_DIV)
		else $error("boot divide LL not the chosen ratio");

	// Clock straps, decoded one cycle later
	a_sys_divide: assert property ($rose(cg_captured) |=>
		sys_div == 3'h4 - {1'b0, $past(addr_pins[14:13], 2)})
		else $error("system divisor decode wrong");
	a_pci_divide: assert property ($rose(cg_captured) && $past(addr_pins[11:10]) == 2'h0 |=>
		pci_div_x2 == 4'h5)
		else $error("PCI divisor LL not 2.5");
	a_pci_mid: assert property ($rose(cg_captured) && $past(addr_pins[11:10]) == 2'h2 |=>
		pci_div_x2 == 4'ha)
		else $error("PCI divisor HL not 5");
	a_pci_slow: assert property ($rose(cg_captured) && $past(addr_pins[11:10]) == 2'h3 |=>
		pci_div_x2 == 4'hc)
		else $error("PCI divisor HH not 6");
	a_core_mult: assert property ($rose(cg_captured) && $past(addr_pins[2:0]) == 3'h0 |=>
		core_mult_x2 == 6'h20)
		else $error("core multiplier LLL not 16");
	a_mult_low: assert property ($rose(cg_captured) && $past(addr_pins[2:0]) == 3'h7 |=>
		core_mult_x2 == 6'h04)
		else $error("core multiplier HHH not 2");
	a_ratio_copy: assert property ($rose(cg_captured) |->
		core_ratio_copy_field == $past(addr_pins[1:0]))
		else $error("core ratio copy wrong");
	// Until captured, the clock fields show the pull-up levels
	a_cg_idle: assert property (!cg_captured |-> cg_raw == BSC_CG_RST)
		else $error("clock straps not at pull-up level before capture");

	// Frozen fields; a main reset alone must not disturb the clock straps
	a_main_hold: assert property (main_captured && $past(main_captured) |-> $stable(raw))
		else $error("main straps changed without reset");
	a_cg_hold: assert property (cg_captured && $past(cg_captured) |-> $stable(cg_raw))
		else $error("clock straps changed without reset");
	a_cg_main_keep: assert property ($rose(main_captured) && $past(cg_captured) |->
		$stable(cg_raw))
		else $error("clock straps disturbed by main reset");

	// Control bit and the board checks that it gates
	a_ctrl_write: assert property (req.wr && req.wr_addr == BSC_OFS_CTRL |=>
		state_reg.check_en == $past(req.wr_data[BSC_CTRL_CHECK_BIT]))
		else $error("check enable not written");
	a_flag_gate: assert property (!state_reg.check_en |=>
		!state_reg.pci_boot_conflict && !state_reg.reserved_low)
		else $error("board check flag set while disabled");
	a_pci_boot_check: assert property (state_reg.check_en && main_captured && !raw[BSC_PIN_BOOT_SRC]
		&& raw[7:6] != 2'h3 |=> state_reg.pci_boot_conflict)
		else $error("PCI boot strap conflict not flagged");
	a_reserved_check: assert property (state_reg.check_en && main_captured
		&& !(&{raw[BSC_PIN_RSVD_HI +: 3], raw[BSC_PIN_RSVD_LO +: 3]}) |=> state_reg.reserved_low)
		else $error("reserved strap pulled low not flagged");

	c_main_capture: cover property ($rose(main_captured));
	c_cg_recapture: cover property (main_captured && $rose(cg_captured));
	c_pci_boot: cover property (main_captured && !main_cfg.boot_source_field);
	c_conflict: cover property ($rose(state_reg.pci_boot_conflict));
	c_reserved_low: cover property ($rose(state_reg.reserved_low));

endmodule

// ===== src/bsc_capture.sv
// One strap sampling group, loaded on the first edge after its reset lifts
`timescale 1ns/10ps
module bsc_capture
	import bsc_pkg::*;
#(
	parameter int W = 7,
	parameter logic [W-1:0] RST = '1
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hold_n,
	input wire logic [W-1:0] pins,
	output logic [W-1:0] value,
	output logic captured
);

	typedef struct packed {
		logic pending;
		logic [W-1:0] value;
	} bsc_cap_state_t;

	bsc_cap_state_t state_reg;
	bsc_cap_state_t state_next;

	initial
	begin
		if (W < 1)
			$error("bsc_capture: W must be at least 1");
	end

	// Held reset re-arms; first free edge samples, then value is frozen
	always_comb
	begin
		state_next = state_reg;
		if (!hold_n)
			state_next.pending = 1'b1;
		else if (state_reg.pending)
		begin
			state_next.value = pins;
			state_next.pending = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_reg <= '{pending: 1'b1, value: RST};
		else
			state_reg <= state_next;
	end

	assign value = state_reg.value;
	assign captured = ~state_reg.pending;

endmodule

// ===== tb/boot_strap_capture_bench.sv
// Self-checking bench for the boot strap capture block
`timescale 1ns/10ps
module boot_strap_capture_bench import bsc_pkg::*;;
	localparam logic [5:0] HLL_X2 = 6'h06;
	localparam logic [2:0] BOOT_LL = 3'h3;
	localparam logic [3:0] PCI_X2 [4] = '{4'h5, 4'h6, 4'ha, 4'hc};
	localparam logic [5:0] MULT_X2 [8] = '{6'h20, 6'h18, 6'h14, 6'h10, HLL_X2, 6'h06, 6'h05, 6'h04};
	localparam logic [2:0] BOOT_X [4] = '{BOOT_LL, 3'h2, 3'h2, 3'h1};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic cg_rst_n = 1'b0;
	logic [BSC_AW-1:0] pull_down = '0;
	logic misfit = 1'b0;
	logic [BSC_AW-1:0] addr_pins;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	bsc_main_cfg_t main_cfg;
	bsc_cg_cfg_t cg_cfg;
	logic [1:0] ratio_copy;
	logic [2:0] sys_div;
	logic [3:0] pci_div_x2;
	logic [5:0] core_mult_x2;
	logic [2:0] boot_div;
	logic main_captured;
	logic cg_captured;
	int bad_count = 0;
	int compares = 0;

	// 25 MHz bus clock
	always #20 hclk = ~hclk;

	bsc_strap_board u_board (.pull_down(pull_down), .misfit(misfit), .addr_pins(addr_pins));

	bsc_boot_strap_capture #(.CORE_HLL_X2(HLL_X2), .BOOT_LL_DIV(BOOT_LL)) u_dut (.hclk(hclk),
		.hresetn(hresetn), .clock_generator_reset_n(cg_rst_n), .addr_pins(addr_pins), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .main_cfg(main_cfg), .cg_cfg(cg_cfg),
		.core_ratio_copy_field(ratio_copy), .sys_div(sys_div), .pci_div_x2(pci_div_x2),
		.core_mult_x2(core_mult_x2), .boot_div(boot_div), .main_captured(main_captured),
		.cg_captured(cg_captured));

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single word transfer; holds each phase until hready is seen high
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= BSC_HSIZE_WORD;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	// Pin levels the board really presents for a wanted strap set
	function automatic logic [19:0] board(input logic [19:0] want);
		logic [19:0] p;
		p = want | 20'h38038;
		if (!p[8])
			p[7:6] = 2'h3;
		return p;
	endfunction

	task automatic check_cg(input logic [19:0] p);
		chk("cg_cfg", {25'h0, p[14:13], p[11:10], p[2:0]}, {25'h0, cg_cfg});
		chk("ratio_copy", {30'h0, p[1:0]}, {30'h0, ratio_copy});
	endtask

	// Both resets pulsed with a new strap set, then fields, ratios and registers
	task automatic apply(input logic [19:0] want);
		logic [19:0] p;
		logic [31:0] rd;
		p = board(want);
		hresetn <= 1'b0;
		cg_rst_n <= 1'b0;
		pull_down <= ~want;
		repeat (2) @(posedge hclk);
		chk("captured_in_reset", 32'h0, {31'h0, main_captured});
		chk("cg_in_reset", 32'h0, {31'h0, cg_captured});
		hresetn <= 1'b1;
		cg_rst_n <= 1'b1;
		@(posedge hclk);
		#1;
		chk("main_captured", 32'h1, {31'h0, main_captured});
		chk("main_cfg", {25'h0, p[19], p[18], p[12], p[9], p[8], p[7:6]}, {25'h0, main_cfg});
		check_cg(p);
		repeat (2) @(posedge hclk);
		chk("sys_div", {29'h0, 3'h4 - {1'b0, p[14:13]}}, {29'h0, sys_div});
		chk("pci_div_x2", {28'h0, PCI_X2[p[11:10]]}, {28'h0, pci_div_x2});
		chk("core_mult_x2", {26'h0, MULT_X2[p[2:0]]}, {26'h0, core_mult_x2});
		chk("boot_div", {29'h0, BOOT_X[p[7:6]]}, {29'h0, boot_div});
		ahb(1'b0, BSC_OFS_CHIP, 32'h0, rd);
		chk("chip", {23'h0, p[2:0], p[11:10], p[14:13], p[12], p[19]}, rd);
		ahb(1'b0, BSC_OFS_PIN, 32'h0, rd);
		chk("pin", {30'h0, p[9], p[18]}, rd);
		ahb(1'b0, BSC_OFS_BOOT, 32'h0, rd);
		chk("boot", {29'h0, p[7:6], p[8]}, rd);
		ahb(1'b0, BSC_OFS_IMAGE, 32'h0, rd);
		chk("image", {12'h0, p}, rd);
		ahb(1'b0, BSC_OFS_STATUS, 32'h0, rd);
		chk("status", 32'h3, rd);
	endtask

	initial
	begin
		#200000;
		bad_count++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		logic [31:0] rd;
		logic [19:0] w;
		logic [19:0] p;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		cg_rst_n <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, BSC_OFS_CTRL, 32'h0, rd);
		chk("ctrl_reset", 32'h1, rd);
		ahb(1'b1, BSC_OFS_CTRL, 32'h0, rd);
		ahb(1'b0, BSC_OFS_CTRL, 32'h0, rd);
		chk("ctrl_rw", 32'h0, rd);
		ahb(1'b0, 8'h40, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		// Every encoding of each field across eight strap sets
		for (int i = 0; i < 8; i++)
		begin
			w = 20'hfffff;
			w[19] = i[0];
			w[18] = i[1];
			w[12] = i[2];
			w[9] = ~i[0];
			w[8] = ~i[0];
			w[7:6] = 2'(i >> 1);
			w[14:13] = i[1:0];
			w[11:10] = i[2:1];
			w[2:0] = i[2:0];
			apply(w);
		end
		p = board(w);
		ahb(1'b1, BSC_OFS_CHIP, 32'hffffffff, rd);
		ahb(1'b0, BSC_OFS_CHIP, 32'h0, rd);
		chk("chip_ro", {23'h0, p[2:0], p[11:10], p[14:13], p[12], p[19]}, rd);
		// Pins move after capture: every field must hold
		pull_down <= 20'hfffff;
		repeat (3) @(posedge hclk);
		#1;
		chk("main_hold", {25'h0, p[19], p[18], p[12], p[9], p[8], p[7:6]}, {25'h0, main_cfg});
		check_cg(p);
		// Clock-generator reset alone recaptures only the clock straps
		@(posedge hclk);
		cg_rst_n <= 1'b0;
		repeat (2) @(posedge hclk);
		#1;
		chk("cg_captured_low", 32'h0, {31'h0, cg_captured});
		@(posedge hclk);
		cg_rst_n <= 1'b1;
		@(posedge hclk);
		#1;
		chk("cg_captured", 32'h1, {31'h0, cg_captured});
		check_cg(board(20'h0));
		chk("main_kept", {25'h0, p[19], p[18], p[12], p[9], p[8], p[7:6]}, {25'h0, main_cfg});
		// Misfitted board, main reset only: PCI boot with slow divide and a reserved pin low
		@(posedge hclk);
		misfit <= 1'b1;
		pull_down <= 20'h001c8;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		chk("cg_kept", 32'h1, {31'h0, cg_captured});
		check_cg(board(20'h0));
		chk("main_misfit", 32'h78, {25'h0, main_cfg});
		repeat (2) @(posedge hclk);
		chk("boot_div_ll", {29'h0, BOOT_LL}, {29'h0, boot_div});
		ahb(1'b0, BSC_OFS_STATUS, 32'h0, rd);
		chk("status_misfit", 32'hf, rd);
		ahb(1'b1, BSC_OFS_CTRL, 32'h0, rd);
		@(posedge hclk);
		ahb(1'b0, BSC_OFS_STATUS, 32'h0, rd);
		chk("status_gated", 32'h3, rd);
		stop_test();
	end
endmodule

// ===== tb/bsc_strap_board.sv
// Board strap network model: pull-ups on every address pin, chosen pull-downs
`timescale 1ns/10ps
module bsc_strap_board
	import bsc_pkg::*;
(
	input wire logic [BSC_AW-1:0] pull_down,
	input wire logic misfit,
	output logic [BSC_AW-1:0] addr_pins
);
	logic [BSC_AW-1:0] fitted;

	// Reserved pins never get a pull-down fitted; a misfitted board skips the board rules
	always_comb
	begin
		fitted = pull_down;
		if (!misfit)
		begin
			fitted = fitted & ~20'h38038;
			if (fitted[BSC_PIN_BOOT_SRC])
				fitted[7:6] = 2'h0;
		end
	end

	// An unstrapped pin floats high on its pull-up
	assign addr_pins = ~fitted;
endmodule
